/* File: logic/iwd_regs.sv */
// Purpose: Independent watchdog with its register file on an Avalon-MM slave.
// Assumes: clk_sys at 100 MHz; slow oscillator and deep-sleep arrive asynchronously.
// Notes: Written values wait in shadows until the next slow oscillator edge.
//
// How it works
// RULE1: Key 0xCCCC starts the counter.
// RULE2: Key 0x5A5A then 0xA5A5 stops it.
// RULE3: Key 0x5555 unlocks control, reload, window.
// RULE4: Other keys relock; locked writes are ignored.
// RULE5: Control bit 5 pauses counting in deep sleep.
// RULE6: Control bit 4 enables the interrupt.
// RULE7: Control bit 3: reset or interrupt on overflow.
// RULE8: Control bits 2:0 divide by four shifted left.
// RULE9: Control write needs unlock and idle pending flag.
// RULE10: Reload is 12 bits, resets 0xFFF, guarded.
// RULE11: Software reads count twice until equal.
// RULE12: Window is 12 bits, resets 0xFFF, disabled.
// RULE13: Status bit 5 shows reload in progress.
// RULE14: Status bit 4 shows counter running.
// RULE15: Status bit 3 set on overflow, write 0 clears.
// RULE16: Status bit 2 shows window transfer pending.
// RULE17: Status bit 1 shows reload transfer pending.
// RULE18: Status bit 0 shows control transfer pending.
// RULE19: Start loads 0xFFF and counts down.
// RULE20: Key 0xAAAA reloads counter and relocks.
// RULE21: Zero count overflows, acts, and reloads.
// RULE22: Early reload resets; window write reloads.
// RULE23: Reserved bits and key register read zero.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "iwd_defines.svh"

module iwd_regs (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Avalon-MM slave.
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Asynchronous inputs.
    input wire logic slow_oscillator,
    input wire logic deep_sleep,
    // Watchdog actions.
    output logic wdt_reset_req,
    output logic wdt_irq
);

    // Returns true when a request addresses the given offset.
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
        hit = (addr == off);
    endfunction

    // Division ratio minus one for a prescaler code.
    function automatic logic [9:0] div_last(input logic [2:0] clock_divider_select);
        div_last = (`IWD_DIV_BASE << clock_divider_select) - 10'h001;
    endfunction

    // Bus answer and read data.
    logic ack_ff;
    logic [31:0] rdata_ff;

    // Synchronisers for the asynchronous pins.
    logic osc_s1_ff;
    logic osc_s2_ff;
    logic osc_s3_ff;
    logic slp_s1_ff;
    logic slp_s2_ff;

    // Lock and stop sequence.
    logic unlocked_ff;
    iwd_pkg::iwd_stop_t stop_ff;

    // Shadows written by software and the copies the counter uses.
    iwd_pkg::iwd_ctrl_t ctrl_sh_ff;
    iwd_pkg::iwd_ctrl_t ctrl_ff;
    logic [11:0] arr_sh_ff;
    logic [11:0] arr_ff;
    logic [11:0] win_sh_ff;
    logic [11:0] win_ff;

    // Pending flags and counter state.
    logic crf_ff;
    logic reload_update_pending_ff;
    logic window_update_pending_ff;
    logic reload_pend_ff;
    logic run_ff;
    logic ov_ff;
    logic [11:0] cnt_ff;
    logic [9:0] div_ff;

    // Action outputs.
    logic rst_req_ff;
    logic irq_ff;

    // Decoded strobes and events.
    logic do_wr;
    logic do_rd;
    logic key_wr;
    logic [15:0] key;
    logic slow_edge;
    logic tick;
    logic overflow;
    logic refresh;
    logic early_reload;

    // One wait state: the request is answered on its second cycle.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign do_wr = avs_write & ack_ff;
    assign do_rd = avs_read & ack_ff;

    // Outputs are driven straight from their flops.
    assign avs_readdata = rdata_ff;
    assign wdt_reset_req = rst_req_ff;
    assign wdt_irq = irq_ff;

    // Acknowledge flop; it drops after each answer so requests never merge.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
        end
    end

    // Key writes need both low byte lanes so a half code never acts.
    assign key_wr = do_wr & hit(avs_address, `IWD_OFF_KEY) & (&avs_byteenable[1:0]);
    assign key = avs_writedata[15:0];
    assign refresh = key_wr & (key == `IWD_KEY_REFRESH) & run_ff;

    // Two flops bring the slow clock in; a third gives the edge.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
        end else begin
            osc_s1_ff <= slow_oscillator;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
        end
    end

    // Two flops bring the deep-sleep level in before anything reads it.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            slp_s1_ff <= 1'b0;
            slp_s2_ff <= 1'b0;
        end else begin
            slp_s1_ff <= deep_sleep;
            slp_s2_ff <= slp_s1_ff;
        end
    end

    // A rising edge of the synchronised slow clock, one cycle long.
    assign slow_edge = osc_s2_ff & ~osc_s3_ff;

    // Prescaler: one counting tick per 4 << prs slow edges, held in deep sleep when the pause bit is set.
    assign tick = slow_edge & run_ff & (div_ff == div_last(ctrl_ff.clock_divider_select))
        & ~(ctrl_ff.pause & slp_s2_ff); // [RULE8] [RULE5]
    assign overflow = tick & (cnt_ff == 12'h000); // [RULE21]

    // Counts slow edges; it restarts whenever the watchdog is stopped.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_ff <= 10'h000;
        end else if (!run_ff) begin
            div_ff <= 10'h000;
        end else if (slow_edge && !(ctrl_ff.pause && slp_s2_ff)) begin // [RULE5]
            if (div_ff >= div_last(ctrl_ff.clock_divider_select)) begin // [RULE8]
                div_ff <= 10'h000;
            end else begin
                div_ff <= div_ff + 10'h001;
            end
        end
    end

    // Lock: only the unlock code opens; every other key closes.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            unlocked_ff <= 1'b0;
        end else if (key_wr) begin
            unlocked_ff <= (key == `IWD_KEY_UNLOCK); // [RULE3] [RULE4] [RULE20]
        end
    end

    // Stop sequence: the second code must be the very next key write.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stop_ff <= iwd_pkg::IWD_STOP_IDLE;
        end else if (key_wr) begin
            case (stop_ff)
                iwd_pkg::IWD_STOP_IDLE: begin
                    if (key == `IWD_KEY_STOP1) begin
                        stop_ff <= iwd_pkg::IWD_STOP_ARMED; // [RULE2]
                    end
                end
                iwd_pkg::IWD_STOP_ARMED: begin
                    if (key == `IWD_KEY_STOP1) begin
                        stop_ff <= iwd_pkg::IWD_STOP_ARMED;
                    end else begin
                        stop_ff <= iwd_pkg::IWD_STOP_IDLE;
                    end
                end
                default: begin
                    // An unknown state falls back to idle.
                    stop_ff <= iwd_pkg::IWD_STOP_IDLE;
                end
            endcase
        end
    end

    // Control shadow and transfer to the counting logic on a slow edge.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_sh_ff <= `IWD_CTRL_RST;
            ctrl_ff <= `IWD_CTRL_RST;
            crf_ff <= 1'b0;
        end else begin
            if (do_wr && hit(avs_address, `IWD_OFF_CTRL) && avs_byteenable[0]
                && unlocked_ff && !crf_ff) begin // [RULE9] [RULE4]
                ctrl_sh_ff <= avs_writedata[`IWD_CTRL_W-1:0];
                crf_ff <= 1'b1; // [RULE18]
            end else if (crf_ff && slow_edge) begin
                ctrl_ff <= ctrl_sh_ff;
                crf_ff <= 1'b0; // [RULE18]
            end
        end
    end

    // Reload value shadow and transfer.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            arr_sh_ff <= `IWD_RELOAD_RST;
            arr_ff <= `IWD_RELOAD_RST;
            reload_update_pending_ff <= 1'b0;
        end else begin
            if (do_wr && hit(avs_address, `IWD_OFF_RELOAD) && (&avs_byteenable[1:0])
                && unlocked_ff && !reload_update_pending_ff) begin // [RULE10] [RULE4]
                arr_sh_ff <= avs_writedata[11:0];
                reload_update_pending_ff <= 1'b1; // [RULE17]
            end else if (reload_update_pending_ff && slow_edge) begin
                arr_ff <= arr_sh_ff;
                reload_update_pending_ff <= 1'b0; // [RULE17]
            end
        end
    end

    // Window shadow and transfer; the transfer itself asks for a reload.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            win_sh_ff <= `IWD_WINDOW_RST;
            win_ff <= `IWD_WINDOW_RST; // [RULE12]
            window_update_pending_ff <= 1'b0;
        end else begin
            if (do_wr && hit(avs_address, `IWD_OFF_WINDOW) && (&avs_byteenable[1:0])
                && unlocked_ff && !window_update_pending_ff) begin // [RULE4]
                win_sh_ff <= avs_writedata[11:0]; // [RULE12]
                window_update_pending_ff <= 1'b1; // [RULE16]
            end else if (window_update_pending_ff && slow_edge) begin
                win_ff <= win_sh_ff;
                window_update_pending_ff <= 1'b0; // [RULE16]
            end
        end
    end

    // Reload request: set by refresh or window transfer, done on a slow edge.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reload_pend_ff <= 1'b0;
        end else if (refresh || (window_update_pending_ff && slow_edge)) begin
            reload_pend_ff <= 1'b1; // [RULE13] [RULE22]
        end else if (slow_edge) begin
            reload_pend_ff <= 1'b0; // [RULE13]
        end
    end

    // Run flag: start code sets it, completed stop sequence clears it.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            run_ff <= 1'b0;
        end else if (key_wr && key == `IWD_KEY_START) begin
            run_ff <= 1'b1; // [RULE1] [RULE14]
        end else if (key_wr && key == `IWD_KEY_STOP2 && stop_ff == iwd_pkg::IWD_STOP_ARMED) begin
            run_ff <= 1'b0; // [RULE2] [RULE14]
        end
    end

    // Down counter. A start while running keeps the count.
    // Reloads win over ticks, so a refresh never loses to a decrement.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= `IWD_COUNT_START;
        end else if (key_wr && key == `IWD_KEY_START && !run_ff) begin
            cnt_ff <= `IWD_COUNT_START; // [RULE19]
        end else if (reload_pend_ff && slow_edge) begin
            cnt_ff <= arr_ff; // [RULE20] [RULE22]
        end else if (overflow) begin
            cnt_ff <= arr_ff; // [RULE21]
        end else if (tick) begin
            cnt_ff <= cnt_ff - 12'h001; // [RULE19]
        end
    end

    // A refresh while the count is above the window value is too early.
    assign early_reload = refresh & (cnt_ff > win_ff); // [RULE22]

    // Overflow flag: hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ov_ff <= 1'b0;
        end else if (overflow) begin
            ov_ff <= 1'b1; // [RULE15]
        end else if (do_wr && hit(avs_address, `IWD_OFF_STATUS) && avs_byteenable[0]
            && !avs_writedata[`IWD_ST_OV]) begin
            ov_ff <= 1'b0; // [RULE15]
        end
    end

    // Reset request: one-cycle pulse on overflow in reset mode or on an early refresh.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_req_ff <= 1'b0;
        end else begin
            rst_req_ff <= (overflow && !ctrl_ff.action) || early_reload; // [RULE7] [RULE22]
        end
    end

    // Interrupt: a level that follows the overflow flag in interrupt mode with the interrupt enable bit set.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= ov_ff && ctrl_ff.action && ctrl_ff.ie; // [RULE6] [RULE7]
        end
    end

    // Read data, latched at the edge that raises the acknowledge.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && !ack_ff) begin
            // Reserved bits, the key word and unmapped words read as zero.
            rdata_ff <= 32'h0000_0000; // [RULE23]
            if (hit(avs_address, `IWD_OFF_CTRL)) begin
                rdata_ff[`IWD_CTRL_W-1:0] <= ctrl_sh_ff;
            end else if (hit(avs_address, `IWD_OFF_RELOAD)) begin
                rdata_ff[11:0] <= arr_sh_ff;
            end else if (hit(avs_address, `IWD_OFF_WINDOW)) begin
                rdata_ff[11:0] <= win_sh_ff;
            end else if (hit(avs_address, `IWD_OFF_COUNT)) begin
                rdata_ff[11:0] <= cnt_ff; // [RULE11]
            end else if (hit(avs_address, `IWD_OFF_STATUS)) begin
                rdata_ff[`IWD_ST_RELOAD] <= reload_pend_ff; // [RULE13]
                rdata_ff[`IWD_ST_RUN] <= run_ff; // [RULE14]
                rdata_ff[`IWD_ST_OV] <= ov_ff; // [RULE15]
                rdata_ff[`IWD_ST_WINDOW_UPDATE_PENDING] <= window_update_pending_ff; // [RULE16]
                rdata_ff[`IWD_ST_RELOAD_UPDATE_PENDING] <= reload_update_pending_ff; // [RULE17]
                rdata_ff[`IWD_ST_CRF] <= crf_ff; // [RULE18]
            end
        end
    end

    // Reads are answered without side effects.
    logic unused_rd;
    assign unused_rd = do_rd;

endmodule

/* File: logic/iwd_defines.svh */
// Purpose: Offsets, field positions, key codes and reset values of the watchdog registers.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave; each register takes one word.
// Notes: Definitions only; the package holds the types.
`ifndef IWD_DEFINES_SVH
`define IWD_DEFINES_SVH

// Register byte offsets.
`define IWD_OFF_KEY 6'h00
`define IWD_OFF_CTRL 6'h04
`define IWD_OFF_RELOAD 6'h08
`define IWD_OFF_STATUS 6'h0C
`define IWD_OFF_WINDOW 6'h10
`define IWD_OFF_COUNT 6'h24

// Key codes.
`define IWD_KEY_START 16'hCCCC
`define IWD_KEY_REFRESH 16'hAAAA
`define IWD_KEY_UNLOCK 16'h5555
`define IWD_KEY_STOP1 16'h5A5A
`define IWD_KEY_STOP2 16'hA5A5

// Control field positions.
`define IWD_CTRL_PAUSE 5
`define IWD_CTRL_IE 4
`define IWD_CTRL_ACTION 3
`define IWD_CTRL_W 6

// Status field positions.
`define IWD_ST_RELOAD 5
`define IWD_ST_RUN 4
`define IWD_ST_OV 3
`define IWD_ST_WINDOW_UPDATE_PENDING 2
`define IWD_ST_RELOAD_UPDATE_PENDING 1
`define IWD_ST_CRF 0

// Reset values and counter constants.
`define IWD_CTRL_RST 6'h00
`define IWD_RELOAD_RST 12'hFFF
`define IWD_WINDOW_RST 12'hFFF
`define IWD_COUNT_START 12'hFFF
`define IWD_DIV_BASE 10'h004

`endif

/* File: logic/iwd_pkg.sv */
// Purpose: Types shared by the watchdog register block.
// Assumes: Field layout as in iwd_defines.svh.
// Notes: Nothing is imported; users write iwd_pkg::name.
package iwd_pkg;

    // Control register fields, bit 5 down to bit 0.
    typedef struct packed {
        logic pause;
        logic ie;
        logic action;
        logic [2:0] clock_divider_select;
    } iwd_ctrl_t;

    // Progress of the two-step stop sequence.
    typedef enum logic {
        IWD_STOP_IDLE,
        IWD_STOP_ARMED
    } iwd_stop_t;

endpackage

/* File: tb/iwd_regs_sva.sv */
// Purpose: Port checks for the watchdog register block.
// Assumes: One clock domain, rst_b active low.
// Notes: Bound to the block at the foot of this file.
`timescale 1ns/1ns
`include "iwd_defines.svh"

module iwd_regs_sva (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Avalon-MM slave.
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Slow side and actions.
    input wire logic slow_oscillator,
    input wire logic deep_sleep,
    input wire logic wdt_reset_req,
    input wire logic wdt_irq
);
    logic rd_done;
    logic narrow;
    logic mapped;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // Decodes the completing read and the class of the word it reads.
    assign rd_done = avs_read && !avs_waitrequest;
    assign narrow = avs_address == `IWD_OFF_CTRL || avs_address == `IWD_OFF_STATUS;
    assign mapped = narrow || avs_address inside {`IWD_OFF_KEY, `IWD_OFF_RELOAD,
        `IWD_OFF_WINDOW, `IWD_OFF_COUNT};

    // A request that starts now, then its single wait state.
    sequence req_rise_s;
        (avs_read || avs_write) && !$past(avs_read || avs_write);
    endsequence
    sequence one_wait_s;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    wait_state_a: assert property (req_rise_s |-> one_wait_s)
        else $error("Waitrequest did not give one wait state.");
    idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("Waitrequest high with no request.");
    data_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("Read data changed without a read.");
    upper_zero_a: assert property (rd_done |-> avs_readdata[31:12] == 20'h0)
        else $error("Reserved read bits not zero.");
    key_zero_a: assert property (rd_done && avs_address == 6'h00
        |-> avs_readdata == 32'h0)
        else $error("Key register read not zero.");
    narrow_reg_a: assert property (rd_done && narrow |-> avs_readdata[31:6] == 26'h0)
        else $error("Control or status reserved bits not zero.");
    unmapped_zero_a: assert property (rd_done && !mapped |-> avs_readdata == 32'h0)
        else $error("Unmapped read not zero.");
    reset_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("Reset request longer than one cycle.");
endmodule

bind iwd_regs iwd_regs_sva iwd_regs_sva_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .slow_oscillator(slow_oscillator), .deep_sleep(deep_sleep),
    .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq));

/* File: tb/iwd_regs_tb.sv */
// Purpose: Self-checking bench for the watchdog register block.
// Assumes: Avalon-MM access with waitrequest; slow clock made from clk_sys.
// Notes: Reload is cut to 3, so overflows come within a few hundred cycles.
`timescale 1ns/1ns
`include "iwd_defines.svh"

module iwd_regs_tb;
    logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, deep_sleep, slow_run;
    logic slow_oscillator, wdt_reset_req, wdt_irq;
    logic [5:0] avs_address;
    logic [2:0] slow_div;
    logic [31:0] avs_writedata, avs_readdata, q, c1, c2, seen;
    int fail_count, compares, cycles, pulses, base;
    logic [5:0] ra [7] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h24, 6'h20};
    logic [31:0] rv [7] = '{32'h0, 32'h0, 32'hFFF, 32'h0, 32'hFFF, 32'hFFF, 32'h0};

    iwd_regs iwd_regs_i (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .slow_oscillator(slow_oscillator), .deep_sleep(deep_sleep),
        .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq));

    // Makes the system clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Slow clock at an eighth of clk_sys, reset pulse count and hang limit.
    always @(posedge clk_sys) begin
        slow_div <= slow_div + {2'h0, slow_run};
        slow_oscillator <= slow_div[2];
        pulses <= pulses + int'(wdt_reset_req === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            finish_test();
        end
    end

    // Prints the verdict and ends the run.
    task finish_test();
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Counts one comparison and reports a difference.
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares = compares + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One access, held until waitrequest is sampled low, then a free cycle.
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    task rd(input logic [5:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask

    task wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask

    // Polls status until the masked flags are zero; seen gathers every flag read.
    task wait_clear(input logic [31:0] m);
        seen = 32'h0;
        q = m;
        while ((q & m) != 32'h0) begin
            rd(`IWD_OFF_STATUS, q);
            seen = seen | q;
        end
    endtask

    // Reads the count until two reads in a row agree.
    task rd_count(output logic [31:0] c);
        c = 32'hFFFF_FFFF;
        q = 32'h0;
        while (c !== q) begin
            q = c;
            rd(`IWD_OFF_COUNT, c);
        end
    endtask

    // Main sequence.
    initial begin
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        deep_sleep = 1'b0;
        slow_run = 1'b1;
        slow_div = 3'h0;
        slow_oscillator = 1'b0;
        q = $urandom(32'h7E69);
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], q);
            chk("reset value", rv[i], q);
        end
        wr(`IWD_OFF_CTRL, $urandom | 32'h1);
        rd(`IWD_OFF_CTRL, q);
        chk("locked control", 32'h0, q);
        wr(`IWD_OFF_KEY, 32'hCCCC);
        repeat (100) @(posedge clk_sys);
        rd_count(c1);
        chk("count after start", 32'h1, {31'h0, c1 < 32'hFFF && c1 > 32'hFF0});
        rd(`IWD_OFF_STATUS, q);
        chk("running", 32'h10, q & 32'h10);
        // Pending flags are seen while the slow clock stands still.
        deep_sleep <= 1'b1;
        slow_run <= 1'b0;
        wr(`IWD_OFF_KEY, 32'h5555);
        wr(`IWD_OFF_CTRL, 32'h38);
        wr(`IWD_OFF_RELOAD, 32'hFFFF_F003);
        rd(`IWD_OFF_STATUS, q);
        chk("pending flags", 32'h3, q & 32'h3);
        slow_run <= 1'b1;
        wait_clear(32'h3);
        rd(`IWD_OFF_CTRL, q);
        chk("control", 32'h38, q);
        rd(`IWD_OFF_RELOAD, q);
        chk("reload", 32'h3, q);
        // Refresh relocks; deep sleep with pause holds the count, waking overflows it.
        wr(`IWD_OFF_KEY, 32'hAAAA);
        wr(`IWD_OFF_CTRL, 32'h0);
        rd(`IWD_OFF_CTRL, q);
        chk("relocked control", 32'h38, q);
        repeat (50) @(posedge clk_sys);
        rd_count(c1);
        repeat (300) @(posedge clk_sys);
        rd_count(c2);
        chk("paused count", c1, c2);
        base = pulses;
        deep_sleep <= 1'b0;
        for (int i = 0; i < 400 && wdt_irq !== 1'b1; i++) @(posedge clk_sys);
        chk("overflow irq", 32'h1, {31'h0, wdt_irq});
        chk("no reset pulse", base, pulses);
        rd(`IWD_OFF_STATUS, q);
        chk("overflow flag", 32'h8, q & 32'h8);
        wr(`IWD_OFF_STATUS, 32'h0);
        rd(`IWD_OFF_STATUS, q);
        chk("overflow cleared", 32'h0, q & 32'h8);
        chk("irq dropped", 32'h0, {31'h0, wdt_irq});
        // Stop takes the two codes only back to back.
        wr(`IWD_OFF_KEY, 32'h5A5A);
        wr(`IWD_OFF_KEY, 32'h1000 | ($urandom & 32'hFFF));
        wr(`IWD_OFF_KEY, 32'hA5A5);
        repeat (40) @(posedge clk_sys);
        rd(`IWD_OFF_STATUS, q);
        chk("still running", 32'h10, q & 32'h10);
        wr(`IWD_OFF_KEY, 32'h5A5A);
        wr(`IWD_OFF_KEY, 32'hA5A5);
        repeat (40) @(posedge clk_sys);
        rd(`IWD_OFF_STATUS, q);
        chk("stopped", 32'h0, q & 32'h10);
        // A window write reloads; an early refresh then asks for a reset.
        wr(`IWD_OFF_KEY, 32'hCCCC);
        wr(`IWD_OFF_KEY, 32'h5555);
        slow_run <= 1'b0;
        wr(`IWD_OFF_WINDOW, 32'h1);
        rd(`IWD_OFF_STATUS, q);
        chk("window pending", 32'h4, q & 32'h4);
        slow_run <= 1'b1;
        wait_clear(32'h24);
        chk("reload seen", 32'h20, seen & 32'h20);
        base = pulses;
        wr(`IWD_OFF_KEY, 32'hAAAA);
        repeat (5) @(posedge clk_sys);
        chk("early refresh reset", 32'h1, {31'h0, pulses != base});
        // With action zero an overflow asks for a reset, not an interrupt.
        wr(`IWD_OFF_KEY, 32'h5555);
        wr(`IWD_OFF_CTRL, 32'h0);
        wait_clear(32'h1);
        base = pulses;
        for (int i = 0; i < 400 && pulses == base; i++) @(posedge clk_sys);
        chk("overflow reset", 32'h1, {31'h0, pulses != base});
        chk("no irq", 32'h0, {31'h0, wdt_irq});
        finish_test();
    end
endmodule
